// ==== core/mdcr_regs.sv ====
// Configuration register slice of a brushed DC motor driver with fault and bridge control logic
// ==========================================================
// Functional notes
// R1: Upper inrush blanking byte feeds 16-bit time
// R2: Bits 7-6 select current regulation behaviour
// R3: Bit 5 selects stall response
// R4: Internal reference bit fixes reference internally
// R5: Blanking 1.8 us or 1.0 us
// R6: Deglitch 2 us or 1 us
// R7: Overcurrent response zero latches outputs off
// R8: Overcurrent response one retries after interval
// R9: Thermal latch or auto resume after hysteresis
// R10: Bits 7-6 select ripple count reporting
// R11: Stall report drives fault output low
// R12: Cycle mode reports regulation when enabled
// R13: Input mode: phase/enable or PWM
// R14: Control source: pins or register bits
// R15: Register inputs ignored unless source set
// R16: Fault clear command clears latches, self-clears
// R17: Code 01 cycle, 00 fixed off-time
// R18: Reads return written values; reset defaults
module mdcr_regs #(
    parameter int RETRY_CYC = mdcr_pkg::RETRY_CYC_DEF
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Bridge input pins
    input  wire logic       pin_in1,
    input  wire logic       pin_in2,
    // Events from analog side
    input  wire logic       ocp_event,
    input  wire logic       tsd_active,
    input  wire logic       stall_detect,
    input  wire logic       in_cur_reg,
    input  wire logic       ripple_over,
    // Configuration outputs
    output logic [15:0]     inrush_blank_time,
    output logic [7:0]      inrush_blank_high_byte,
    output logic [1:0]      current_reg_behaviour,
    output logic            stall_response_select,
    output logic            int_ref_select,
    output logic [7:0]      sense_blank_cycles,
    output logic [7:0]      deglitch_cycles,
    output logic [1:0]      ripple_count_report,
    output logic            cycle_mode_active,
    output logic            fixed_off_active,
    // Bridge outputs
    output logic            bridge_input_mode,
    output logic            bridge_in1,
    output logic            bridge_in2,
    output logic            outputs_enable,
    // Fault pin
    output logic            fault_out_n,
    output logic            fault_out_oe
);

    localparam int TIMER_W_L = mdcr_pkg::TIMER_W;

    logic [7:0]  inrush_hi_r;
    logic [7:0]  mode_time_r;
    logic [7:0]  report_br_r;
    logic [7:0]  inrush_lo_in;
    logic        ocp_latch_r;
    logic        tsd_latch_r;
    logic        retry_busy_r;
    logic [TIMER_W_L-1:0] retry_cnt_r;
    logic        clear_pulse;
    logic        fault_low;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==========================================================
    // Register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            inrush_hi_r <= mdcr_pkg::RST_INRUSH_HI;
            mode_time_r <= mdcr_pkg::RST_MODE_TIME;
            report_br_r <= mdcr_pkg::RST_REPORT_BR; // R18
        end else if (reg_wr) begin
            if (hit(reg_addr, mdcr_pkg::OFS_INRUSH_HI)) begin
                inrush_hi_r <= reg_wdata; // R1
            end
            if (hit(reg_addr, mdcr_pkg::OFS_MODE_TIME)) begin
                mode_time_r <= reg_wdata;
            end
            if (hit(reg_addr, mdcr_pkg::OFS_REPORT_BR)) begin
                report_br_r <= reg_wdata;
            end
        end
    end

    // Command bit is a write strobe only; it reads back as zero
    assign clear_pulse = reg_wr && hit(reg_addr, mdcr_pkg::OFS_FAULT_CMD)
                         && reg_wdata[mdcr_pkg::FC_CLEAR]; // R16

    // ==========================================================
    // Read data
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                mdcr_pkg::OFS_INRUSH_HI: reg_rdata <= inrush_hi_r; // R18
                mdcr_pkg::OFS_MODE_TIME: reg_rdata <= mode_time_r;
                mdcr_pkg::OFS_REPORT_BR: reg_rdata <= report_br_r;
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Configuration decode
    // Lower inrush byte lives elsewhere; it enters as zero here
    assign inrush_lo_in           = 8'h00;
    assign inrush_blank_high_byte = inrush_hi_r;
    assign inrush_blank_time      = {inrush_hi_r, inrush_lo_in}; // R1
    assign current_reg_behaviour  = mode_time_r[mdcr_pkg::MT_CURRENT_REG_BEHAVIOUR_HI:mdcr_pkg::MT_CURRENT_REG_BEHAVIOUR_LO]; // R2
    assign stall_response_select  = mode_time_r[mdcr_pkg::MT_STALL_RESPONSE_SELECT]; // R3
    assign int_ref_select         = mode_time_r[mdcr_pkg::MT_INTREF]; // R4
    assign sense_blank_cycles     = mode_time_r[mdcr_pkg::MT_BLANK] ?
                                    8'(mdcr_pkg::BLANK_SHORT_CYC) : 8'(mdcr_pkg::BLANK_LONG_CYC); // R5
    assign deglitch_cycles        = mode_time_r[mdcr_pkg::MT_DEG] ?
                                    8'(mdcr_pkg::DEG_SHORT_CYC) : 8'(mdcr_pkg::DEG_LONG_CYC); // R6
    assign ripple_count_report    = report_br_r[mdcr_pkg::RB_RC_HI:mdcr_pkg::RB_RC_LO]; // R10
    assign cycle_mode_active      = (current_reg_behaviour == mdcr_pkg::REG_CYCLE); // R17
    assign fixed_off_active       = (current_reg_behaviour == mdcr_pkg::REG_FIXED_OFF); // R17

    // ==========================================================
    // Bridge control
    assign bridge_input_mode = report_br_r[mdcr_pkg::RB_BRIDGE_INPUT_MODE]; // R13
    // Register bits only reach the bridge while the source bit selects them
    assign bridge_in1 = report_br_r[mdcr_pkg::RB_SRC] ? report_br_r[mdcr_pkg::RB_IN1] : pin_in1; // R14 R15
    assign bridge_in2 = report_br_r[mdcr_pkg::RB_SRC] ? report_br_r[mdcr_pkg::RB_IN2] : pin_in2; // R14 R15

    // ==========================================================
    // Overcurrent: latch or auto-retry
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ocp_latch_r <= 1'b0;
        end else if (ocp_event && !mode_time_r[mdcr_pkg::MT_OCP]) begin
            ocp_latch_r <= 1'b1; // R7
        end else if (clear_pulse) begin
            ocp_latch_r <= 1'b0; // R16
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            retry_busy_r <= 1'b0;
            retry_cnt_r  <= '0;
        end else if (ocp_event && mode_time_r[mdcr_pkg::MT_OCP]) begin
            retry_busy_r <= 1'b1; // R8
            retry_cnt_r  <= TIMER_W_L'(RETRY_CYC - 1);
        end else if (retry_busy_r) begin
            if (retry_cnt_r == '0) begin
                retry_busy_r <= 1'b0; // R8
            end else begin
                retry_cnt_r <= retry_cnt_r - 1'b1;
            end
        end
    end

    // ==========================================================
    // Overtemperature: latch, or follow the hysteresis-cleared indication
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tsd_latch_r <= 1'b0;
        end else if (tsd_active && !mode_time_r[mdcr_pkg::MT_TSD]) begin
            tsd_latch_r <= 1'b1; // R9
        end else if (clear_pulse) begin
            tsd_latch_r <= 1'b0; // R16
        end
    end

    assign outputs_enable = !(ocp_latch_r || retry_busy_r || tsd_latch_r
                              || (tsd_active && mode_time_r[mdcr_pkg::MT_TSD])); // R7 R8 R9

    // ==========================================================
    // Fault output, open drain: drives low only
    assign fault_low = (report_br_r[mdcr_pkg::RB_STALL] && stall_detect) // R11
                    || (cycle_mode_active && report_br_r[mdcr_pkg::RB_CBC] && in_cur_reg) // R12
                    || (ripple_count_report != 2'h0 && ripple_over) // R10
                    || ocp_latch_r || tsd_latch_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_out_oe <= 1'b0;
        end else begin
            fault_out_oe <= fault_low;
        end
    end
    assign fault_out_n = 1'b0;

    // ==========================================================
    // Checks
    chk_src_pins: assert property (@(posedge mclk) disable iff (!rst_n)
        !report_br_r[mdcr_pkg::RB_SRC] |-> (bridge_in1 == pin_in1 && bridge_in2 == pin_in2)) // R15
        else $error("bridge not following pins");
    chk_ocp_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        (ocp_event && !mode_time_r[mdcr_pkg::MT_OCP]) |=> (!outputs_enable && ocp_latch_r)) // R7
        else $error("overcurrent did not latch off");
    chk_ocp_retry: assert property (@(posedge mclk) disable iff (!rst_n)
        (ocp_event && mode_time_r[mdcr_pkg::MT_OCP]) |=> !outputs_enable) // R8
        else $error("overcurrent retry did not disable");
    chk_clear_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
        (clear_pulse && !ocp_event && !tsd_active) |=> (!ocp_latch_r && !tsd_latch_r)) // R16
        else $error("fault clear failed");
    chk_stall_report: assert property (@(posedge mclk) disable iff (!rst_n)
        (stall_detect && report_br_r[mdcr_pkg::RB_STALL]) |=> fault_out_oe) // R11
        else $error("stall not reported");
    chk_cycle_reg_report: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_cur_reg && cycle_mode_active && report_br_r[mdcr_pkg::RB_CBC]) |=> fault_out_oe) // R12
        else $error("cycle regulation not reported");
    chk_blank_time: assert property (@(posedge mclk) disable iff (!rst_n)
        sense_blank_cycles == (mode_time_r[mdcr_pkg::MT_BLANK] ? 8'd10 : 8'd18)) // R5
        else $error("blanking count wrong");
    chk_deg_time: assert property (@(posedge mclk) disable iff (!rst_n)
        deglitch_cycles == (mode_time_r[mdcr_pkg::MT_DEG] ? 8'd10 : 8'd20)) // R6
        else $error("deglitch count wrong");
    chk_readback: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == mdcr_pkg::OFS_REPORT_BR) |=> reg_rdata == $past(report_br_r)) // R18
        else $error("readback mismatch");

    // ==========================================================
    // Field checks: each of the six directly mapped field outputs must follow the byte last written
    chk_inrush_byte: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_INRUSH_HI)
        |=> inrush_blank_high_byte == $past(reg_wdata)) // R1
        else $error("inrush byte not taken");
    chk_current_reg_behaviour_field: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_MODE_TIME)
        |=> current_reg_behaviour == $past(reg_wdata[mdcr_pkg::MT_CURRENT_REG_BEHAVIOUR_HI:mdcr_pkg::MT_CURRENT_REG_BEHAVIOUR_LO])) // R2
        else $error("regulation field not taken");
    chk_stall_response_select_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_MODE_TIME)
        |=> stall_response_select == $past(reg_wdata[mdcr_pkg::MT_STALL_RESPONSE_SELECT])) // R3
        else $error("stall response bit not taken");
    chk_intref_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_MODE_TIME)
        |=> int_ref_select == $past(reg_wdata[mdcr_pkg::MT_INTREF])) // R4
        else $error("reference bit not taken");
    chk_rc_field: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_REPORT_BR)
        |=> ripple_count_report == $past(reg_wdata[mdcr_pkg::RB_RC_HI:mdcr_pkg::RB_RC_LO])) // R10
        else $error("ripple report field not taken");
    chk_bridge_input_mode_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr == mdcr_pkg::OFS_REPORT_BR)
        |=> bridge_input_mode == $past(reg_wdata[mdcr_pkg::RB_BRIDGE_INPUT_MODE])) // R13
        else $error("input mode bit not taken");
    // Unmapped offsets are reserved: a stray write must leave every register alone
    chk_wr_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr && reg_addr != mdcr_pkg::OFS_INRUSH_HI && reg_addr != mdcr_pkg::OFS_MODE_TIME
         && reg_addr != mdcr_pkg::OFS_REPORT_BR)
        |=> ($stable(inrush_hi_r) && $stable(mode_time_r) && $stable(report_br_r))) // R18
        else $error("stray write changed a register");
    chk_reset_vals: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> (mode_time_r == mdcr_pkg::RST_MODE_TIME
                          && report_br_r == mdcr_pkg::RST_REPORT_BR)) // R18
        else $error("reset values wrong");

    // ==========================================================
    // Bridge and fault checks
    chk_src_regs: assert property (@(posedge mclk) disable iff (!rst_n)
        report_br_r[mdcr_pkg::RB_SRC]
        |-> (bridge_in1 == report_br_r[mdcr_pkg::RB_IN1] && bridge_in2 == report_br_r[mdcr_pkg::RB_IN2])) // R14
        else $error("bridge not following register bits");
    // A latched fault must survive until the clear command arrives
    chk_ocp_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (ocp_latch_r && !clear_pulse) |=> ocp_latch_r) // R7
        else $error("overcurrent latch dropped");
    chk_retry_end: assert property (@(posedge mclk) disable iff (!rst_n)
        (retry_busy_r && retry_cnt_r == '0 && !ocp_event)
        |=> !retry_busy_r) // R8
        else $error("retry did not end");
    chk_tsd_auto: assert property (@(posedge mclk) disable iff (!rst_n)
        (tsd_active && mode_time_r[mdcr_pkg::MT_TSD]) |-> !outputs_enable) // R9
        else $error("thermal auto mode left outputs on");
    chk_tsd_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        (tsd_active && !mode_time_r[mdcr_pkg::MT_TSD]) |=> tsd_latch_r) // R9
        else $error("thermal event did not latch");
    chk_cmd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == mdcr_pkg::OFS_FAULT_CMD) |=> reg_rdata == 8'h00) // R16
        else $error("clear command read back nonzero");
    chk_ripple_rep: assert property (@(posedge mclk) disable iff (!rst_n)
        (ripple_over && ripple_count_report != 2'h0) |=> fault_out_oe) // R10
        else $error("ripple not reported");
    // Pin must release once no source asks for it, or the host sees a phantom fault
    chk_fault_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        (!stall_detect && !in_cur_reg && !ripple_over && !ocp_latch_r && !tsd_latch_r)
        |=> !fault_out_oe) // R11
        else $error("fault pin held without cause");

endmodule

// ==== core/mdcr_pkg.sv ====
// Package: register map, field positions, reset values and timing constants for the motor driver config slice
package mdcr_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_INRUSH_HI  = 8'h0b;
    localparam logic [7:0] OFS_MODE_TIME  = 8'h0c;
    localparam logic [7:0] OFS_REPORT_BR  = 8'h0d;
    localparam logic [7:0] OFS_FAULT_CMD  = 8'h09;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_INRUSH_HI  = 8'h00;
    localparam logic [7:0] RST_MODE_TIME  = 8'h63;
    localparam logic [7:0] RST_REPORT_BR  = 8'h38;

    // ==========================================================
    // Field positions, mode/timing register
    localparam int MT_CURRENT_REG_BEHAVIOUR_HI = 7;
    localparam int MT_CURRENT_REG_BEHAVIOUR_LO = 6;
    localparam int MT_STALL_RESPONSE_SELECT    = 5;
    localparam int MT_INTREF   = 4;
    localparam int MT_BLANK    = 3;
    localparam int MT_DEG      = 2;
    localparam int MT_OCP      = 1;
    localparam int MT_TSD      = 0;

    // Field positions, report/bridge register
    localparam int RB_RC_HI    = 7;
    localparam int RB_RC_LO    = 6;
    localparam int RB_STALL    = 5;
    localparam int RB_CBC      = 4;
    localparam int RB_BRIDGE_INPUT_MODE    = 3;
    localparam int RB_SRC      = 2;
    localparam int RB_IN1      = 1;
    localparam int RB_IN2      = 0;

    // Fault-clear command bit in its own register
    localparam int FC_CLEAR    = 1;

    // Regulation codes
    localparam logic [1:0] REG_FIXED_OFF = 2'h0;
    localparam logic [1:0] REG_CYCLE     = 2'h1;

    // ==========================================================
    // Timing, in ns, and derived cycle counts at 10 MHz
    localparam int CLK_NS         = 100;
    localparam int BLANK_LONG_NS  = 1800;
    localparam int BLANK_SHORT_NS = 1000;
    localparam int DEG_LONG_NS    = 2000;
    localparam int DEG_SHORT_NS   = 1000;
    localparam int BLANK_LONG_CYC  = (BLANK_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEG_LONG_CYC    = (DEG_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEG_SHORT_CYC   = (DEG_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RETRY_CYC_DEF   = 10000;
    localparam int TIMER_W         = 16;

endpackage

// ==== tb/mdcr_host.sv ====
// Host-side model that drives the register port of the config slice
module mdcr_host (
    // Clock
    input  wire logic       mclk,
    // Register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // ==========================================================
    // One transfer: held across one rising edge, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Idle bus shows inverted values so a stale sample cannot pass
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule

// ==== tb/tb_mdcr_regs.sv ====
// Self-checking bench for the motor driver config slice
module tb_mdcr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, reg_wr, reg_rd, pin_in1, pin_in2, ocp_event, tsd_active;
    logic        stall_detect, in_cur_reg, ripple_over, stall_response_select, int_ref_select;
    logic        cycle_mode_active, fixed_off_active, bridge_input_mode, bridge_in1, bridge_in2;
    logic        outputs_enable, fault_out_n, fault_out_oe;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, inrush_blank_high_byte, sense_blank_cycles, deglitch_cycles;
    logic [1:0]  current_reg_behaviour, ripple_count_report, rd_p;
    logic [15:0] inrush_blank_time;
    logic [31:0] seed, v;
    logic [7:0]  exp_q[$];
    int          err_count, check_count, cyc;

    mdcr_regs #(.RETRY_CYC(8)) DUT (.*);
    mdcr_host u_host (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ==========================================================
    // Read monitor: data is settled by the second falling edge
    always @(posedge mclk) rd_p <= {rd_p[0], reg_rd};
    always @(negedge mclk) begin
        if (rd_p[1] === 1'b1 && exp_q.size() > 0)
            chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ==========================================================
    initial begin
        {rst_n, pin_in1, pin_in2, ocp_event, tsd_active, stall_detect, in_cur_reg, ripple_over} = 8'h00;
        rd_p = 2'b00;
        seed = 32'h0000_4b05;
        repeat (16) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        rd(mdcr_pkg::OFS_INRUSH_HI, mdcr_pkg::RST_INRUSH_HI);
        rd(mdcr_pkg::OFS_MODE_TIME, mdcr_pkg::RST_MODE_TIME);
        rd(mdcr_pkg::OFS_REPORT_BR, mdcr_pkg::RST_REPORT_BR);
        rd(8'h0a, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            {pin_in1, pin_in2} = v[25:24];
            wr(mdcr_pkg::OFS_INRUSH_HI, v[7:0]);
            wr(mdcr_pkg::OFS_MODE_TIME, v[15:8]);
            wr(mdcr_pkg::OFS_REPORT_BR, v[23:16]);
            chk("inrush", inrush_blank_time, {v[7:0], 8'h00});
            chk("inrush_hi", {8'h00, inrush_blank_high_byte}, {8'h00, v[7:0]});
            chk("current_reg_behaviour", {14'h0000, current_reg_behaviour}, {14'h0000, v[15:14]});
            chk("stall_response_select", {15'h0000, stall_response_select}, {15'h0000, v[13]});
            chk("intref", {15'h0000, int_ref_select}, {15'h0000, v[12]});
            chk("blank", {8'h00, sense_blank_cycles}, v[11] ? 16'd10 : 16'd18);
            chk("deglitch", {8'h00, deglitch_cycles}, v[10] ? 16'd10 : 16'd20);
            chk("regmode", {14'h0000, cycle_mode_active, fixed_off_active}, {14'h0000, v[15:14] == 2'b01, v[15:14] == 2'b00});
            chk("ripple_count_report", {14'h0000, ripple_count_report}, {14'h0000, v[23:22]});
            chk("bridge_input_mode", {15'h0000, bridge_input_mode}, {15'h0000, v[19]});
            chk("bridge", {14'h0000, bridge_in1, bridge_in2}, {14'h0000, v[18] ? v[17:16] : v[25:24]});
            rd(mdcr_pkg::OFS_INRUSH_HI, v[7:0]);
            rd(mdcr_pkg::OFS_MODE_TIME, v[15:8]);
            rd(mdcr_pkg::OFS_REPORT_BR, v[23:16]);
        end
        $display("test random_fields done");
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h00);
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h00);
        ocp_event = 1'b1;
        wait_n(1);
        ocp_event = 1'b0;
        wait_n(20);
        chk("ocp_latch", {15'h0000, outputs_enable}, 16'h0000);
        chk("ocp_pin", {15'h0000, fault_out_oe}, 16'h0001);
        wr(mdcr_pkg::OFS_FAULT_CMD, 8'h02);
        wait_n(1);
        chk("clear_en", {15'h0000, outputs_enable}, 16'h0001);
        chk("clear_pin", {15'h0000, fault_out_oe}, 16'h0000);
        rd(mdcr_pkg::OFS_FAULT_CMD, 8'h00);
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h02);
        ocp_event = 1'b1;
        wait_n(1);
        ocp_event = 1'b0;
        wait_n(3);
        chk("retry_off", {15'h0000, outputs_enable}, 16'h0000);
        wait_n(8);
        chk("retry_on", {15'h0000, outputs_enable}, 16'h0001);
        $display("test overcurrent done");
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h00);
        tsd_active = 1'b1;
        wait_n(1);
        tsd_active = 1'b0;
        wait_n(3);
        chk("tsd_latch", {15'h0000, outputs_enable}, 16'h0000);
        wr(mdcr_pkg::OFS_FAULT_CMD, 8'h02);
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h01);
        tsd_active = 1'b1;
        wait_n(3);
        chk("tsd_auto_off", {15'h0000, outputs_enable}, 16'h0000);
        tsd_active = 1'b0;
        wait_n(3);
        chk("tsd_auto_on", {15'h0000, outputs_enable}, 16'h0001);
        $display("test thermal done");
        stall_detect = 1'b1;
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h20);
        wait_n(2);
        chk("stall_on", {15'h0000, fault_out_oe}, 16'h0001);
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h00);
        wait_n(2);
        chk("stall_off", {15'h0000, fault_out_oe}, 16'h0000);
        stall_detect = 1'b0;
        in_cur_reg = 1'b1;
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h43);
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h10);
        wait_n(2);
        chk("cbc_on", {15'h0000, fault_out_oe}, 16'h0001);
        wr(mdcr_pkg::OFS_MODE_TIME, 8'h03);
        wait_n(2);
        chk("cbc_fixed", {15'h0000, fault_out_oe}, 16'h0000);
        in_cur_reg = 1'b0;
        ripple_over = 1'b1;
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h40);
        wait_n(2);
        chk("ripple_on", {15'h0000, fault_out_oe}, 16'h0001);
        wr(mdcr_pkg::OFS_REPORT_BR, 8'h00);
        wait_n(2);
        chk("ripple_off", {15'h0000, fault_out_oe}, 16'h0000);
        ripple_over = 1'b0;
        chk("pin_level", {15'h0000, fault_out_n}, 16'h0000);
        $display("test reporting done");
        wait_n(4);
        test_done();
    end
endmodule
